/* ppgd_dead_time.sv */
// Break-before-make stage: turns a phase toggle into two gates with dead time.
// Assumes phase changes no faster than the dead time plus one cycle.
`timescale 1ns/1ns
`default_nettype none
module ppgd_dead_time
  import ppgd_pkg::*;
#(
  parameter int DEAD_CYC = DEAD_TIME_LF_CYC
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic run,
  input  wire logic phase,
  output logic      gate_a,
  output logic      gate_b,
  output logic      in_dead
);

  localparam int CW = $clog2(DEAD_CYC + 1);

  ppgd_state_t   state_q, state_d;
  logic [CW-1:0] cnt_q,   cnt_d;
  logic          ph_q,    ph_d;
  logic          ga_q,    ga_d;
  logic          gb_q,    gb_d;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    ph_d    = ph_q;
    ga_d    = 1'b0;
    gb_d    = 1'b0;
    case (state_q)
      PPGD_IDLE: begin
        if (run) begin
          state_d = PPGD_DEAD;
          cnt_d   = CW'(DEAD_CYC);
          ph_d    = phase;
        end
      end
      PPGD_DEAD: begin
        // Both low before either goes high
        if (cnt_q > CW'(1)) begin
          cnt_d = cnt_q - CW'(1);
        end else begin
          state_d = PPGD_DRIVE;
          ga_d    = ~ph_q;
          gb_d    = ph_q;
        end
      end
      PPGD_DRIVE: begin
        ga_d = ~ph_q;
        gb_d = ph_q;
        // Any phase change opens a full dead time first
        if (phase != ph_q) begin
          state_d = PPGD_DEAD;
          cnt_d   = CW'(DEAD_CYC);
          ph_d    = phase;
          ga_d    = 1'b0;
          gb_d    = 1'b0;
        end
      end
      default: state_d = PPGD_IDLE;
    endcase
    if (!run) begin
      // Both gates low while stopped
      state_d = PPGD_IDLE;
      ga_d    = 1'b0;
      gb_d    = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= PPGD_IDLE;
      cnt_q   <= '0;
      ph_q    <= 1'b0;
      ga_q    <= 1'b0;
      gb_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      ph_q    <= ph_d;
      ga_q    <= ga_d;
      gb_q    <= gb_d;
    end
  end

  assign gate_a  = ga_q;
  assign gate_b  = gb_q;
  assign in_dead = (state_q != PPGD_DRIVE);

endmodule : ppgd_dead_time
`default_nettype wire

/* ppgd_far_side.sv */
// Far side of the drains: primary pull-up on each drain and a clock source.
// Assumes the bench starts and stops the clock source between checks.
`timescale 1ns/1ns
`default_nettype none
module ppgd_far_side #(
  parameter int HALF = 200
) (
  input  wire logic core_clk,
  input  wire logic ext_run,
  input  wire logic oe_a,
  input  wire logic oe_b,
  input  wire logic val_a,
  input  wire logic val_b,
  output wire logic ext_clk,
  output wire logic pin_a,
  output wire logic pin_b
);
  int   cnt_q = 0;
  logic clk_q = 1'b0;
  ////////////////////////////////////////////////////////////////////////////////
  // Released drain sits at the supply through its primary half
  assign pin_a   = oe_a ? val_a : 1'b1;
  assign pin_b   = oe_b ? val_b : 1'b1;
  assign ext_clk = clk_q;
  // 400 cycles a period is 312.5 kHz; stopped source leaves the pull-down
  always @(posedge core_clk) begin
    cnt_q <= ext_run ? (cnt_q + 1) % (2 * HALF) : 0;
    clk_q <= ext_run && (cnt_q < HALF);
  end
endmodule : ppgd_far_side
`default_nettype wire

/* ppgd_pkg.sv */
// Package for the push-pull gate drive sequencer: timing constants and states.
// Assumes a single 125 MHz core clock.
`default_nettype none
package ppgd_pkg;

  localparam int CLK_PERIOD_NS = 8;

  // Dead time, low-frequency and high-frequency variants
  localparam int DEAD_TIME_LF_NS  = 115;
  localparam int DEAD_TIME_HF_NS  = 90;
  localparam int DEAD_TIME_LF_CYC = (DEAD_TIME_LF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEAD_TIME_HF_CYC = (DEAD_TIME_HF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // External clock fail timeout window, 10 to 25 us; counted at the least figure
  localparam int EXT_FAIL_MIN_US  = 10;
  localparam int EXT_FAIL_MAX_US  = 25;
  localparam int EXT_FAIL_CYC     = (EXT_FAIL_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Soft-start period, 1 to 8 ms; nominal ramp taken at the least figure
  localparam int SOFT_START_MIN_MS = 1;
  localparam int SOFT_START_MAX_MS = 8;
  localparam int SOFT_START_CYC    = (SOFT_START_MIN_MS * 1000000 + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;

  // Internal oscillator half-period (core cycles) and spread range
  localparam int OSC_HALF_LF_CYC = 391;
  localparam int OSC_HALF_HF_CYC = 148;
  localparam int SPREAD_SPAN     = 32;

  // Soft-start duty resolution
  localparam int RAMP_BITS = 8;

  // Valid external edges counted before the next one makes external clock trusted
  localparam int EXT_LOCK_EDGES = 4;

  typedef enum logic [1:0] {
    PPGD_IDLE,
    PPGD_DEAD,
    PPGD_DRIVE
  } ppgd_state_t;

endpackage : ppgd_pkg
`default_nettype wire

/* ppgd_sequencer.sv */
// Push-pull gate drive sequencer: clock select, divide by two, soft start,
// output enables for two open-drain drains.
// Assumes enable, ext clock and supply flags are already synchronous to core_clk.
//
// Operation
// - Divide selected clock by two, complementary gates.
// - Dead time before either gate rises.
// - External clock rising edge toggles divider.
// - Lost external clock falls back to internal.
// - Internal oscillator frequency is spread.
// - No spreading while external clock used.
// - Soft-start ramp on power-up and enable rise.
// - Disabled or undervoltage tri-states both drains.
// - Enable pulled low, undriven means disabled.
// - Start oscillator once supply reaches start level.
// - Ext clock pulled down, absent when invalid.
`timescale 1ns/1ns
`default_nettype none
module ppgd_sequencer
  import ppgd_pkg::*;
#(
  parameter bit HIGH_FREQ     = 1'b0,
  parameter int EXT_FAIL_CNT  = EXT_FAIL_CYC,
  parameter int SOFT_CNT      = SOFT_START_CYC
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic enable_in,
  input  wire logic ext_clk_in,
  input  wire logic supply_start_ok,
  input  wire logic supply_above_lockout,
  output logic      drain_out_a,
  output logic      drain_out_a_oe,
  output logic      drain_out_b,
  output logic      drain_out_b_oe,
  output logic      ext_clock_active,
  output logic      soft_start_busy,
  output logic      enable_pull_down,
  output logic      ext_clk_pull_down
);

  localparam int OSC_HALF   = HIGH_FREQ ? OSC_HALF_HF_CYC : OSC_HALF_LF_CYC;
  localparam int DEAD_CYC   = HIGH_FREQ ? DEAD_TIME_HF_CYC : DEAD_TIME_LF_CYC;
  localparam int OW         = $clog2(OSC_HALF + SPREAD_SPAN + 1);
  localparam int FW         = $clog2(EXT_FAIL_CNT + 1);
  localparam int SW         = $clog2(SOFT_CNT + 1);
  localparam int LW         = $clog2(EXT_LOCK_EDGES + 1);
  localparam int STEP_CYC   = (SOFT_CNT >> RAMP_BITS) > 0 ? (SOFT_CNT >> RAMP_BITS) : 1;
  localparam int FLIP_GAP   = 2 * DEAD_CYC + 2;
  localparam int HW         = $clog2(FLIP_GAP + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Power and enable state

  logic run;
  logic en_q, en_d;
  logic up_q, up_d;

  // Enable pin pulled low inside; undriven level reads as low
  assign enable_pull_down  = 1'b1;
  // Ext clock pin pulled low inside so a floating pin gives no edges
  assign ext_clk_pull_down = 1'b1;

  always_comb begin
    up_d = up_q;
    // Start at the upper threshold, lock out below the lower one
    if (!supply_above_lockout) begin
      up_d = 1'b0;
    end else if (supply_start_ok) begin
      up_d = 1'b1;
    end
    en_d = enable_in;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      up_q <= 1'b0;
      en_q <= 1'b0;
    end else begin
      up_q <= up_d;
      en_q <= en_d;
    end
  end

  assign run = up_q & enable_in;

  ////////////////////////////////////////////////////////////////////////////
  // Internal oscillator with spread spectrum

  logic [OW-1:0] osc_cnt_q, osc_cnt_d;
  logic [4:0]    lfsr_q,    lfsr_d;
  logic          osc_tick;
  logic          use_ext;

  always_comb begin
    osc_cnt_d = osc_cnt_q + OW'(1);
    lfsr_d    = lfsr_q;
    osc_tick  = 1'b0;
    if (!run) begin
      osc_cnt_d = '0;
    end else if (osc_cnt_q >= OW'(OSC_HALF) + (use_ext ? OW'(0) : OW'(lfsr_q))) begin
      // Half period dithered by a pseudo-random offset
      osc_tick  = 1'b1;
      osc_cnt_d = '0;
      lfsr_d    = {lfsr_q[3:0], lfsr_q[4] ^ lfsr_q[2]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      osc_cnt_q <= '0;
      lfsr_q    <= 5'h01;
    end else begin
      osc_cnt_q <= osc_cnt_d;
      lfsr_q    <= lfsr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External clock detection and fail-safe

  logic          ext_prev_q, ext_prev_d;
  logic [FW-1:0] fail_q,     fail_d;
  logic [LW-1:0] lock_q,     lock_d;
  logic          use_q,      use_d;
  logic          ext_rise;

  assign ext_rise = ext_clk_in & ~ext_prev_q;

  always_comb begin
    ext_prev_d = ext_clk_in;
    fail_d     = fail_q;
    lock_d     = lock_q;
    use_d      = use_q;
    if (!run) begin
      fail_d = '0;
      lock_d = '0;
      use_d  = 1'b0;
    end else if (ext_rise) begin
      fail_d = '0;
      if (lock_q < LW'(EXT_LOCK_EDGES)) begin
        lock_d = lock_q + LW'(1);
      end else begin
        use_d = 1'b1;
      end
    end else if (fail_q >= FW'(EXT_FAIL_CNT)) begin
      // No edge for the timeout: back to internal oscillator
      lock_d = '0;
      use_d  = 1'b0;
    end else begin
      fail_d = fail_q + FW'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ext_prev_q <= 1'b0;
      fail_q     <= '0;
      lock_q     <= '0;
      use_q      <= 1'b0;
    end else begin
      ext_prev_q <= ext_prev_d;
      fail_q     <= fail_d;
      lock_q     <= lock_d;
      use_q      <= use_d;
    end
  end

  assign use_ext          = use_q;
  assign ext_clock_active = use_q;

  ////////////////////////////////////////////////////////////////////////////
  // Divide by two

  logic          phase_q, phase_d;
  logic [HW-1:0] hold_q,  hold_d;
  logic          flip_req;

  // Toggle request from whichever source is selected
  assign flip_req = use_ext ? ext_rise : osc_tick;

  always_comb begin
    phase_d = phase_q;
    hold_d  = hold_q;
    if (hold_q < HW'(FLIP_GAP)) begin
      hold_d = hold_q + HW'(1);
    end
    if (!run) begin
      // Known phase on every restart
      phase_d = 1'b0;
      hold_d  = '0;
    end else if (flip_req && (hold_q >= HW'(FLIP_GAP))) begin
      // Toggle per selected edge; handover leaves phase intact
      // Edges less than two dead times plus three cycles apart are dropped, so an out-of-range
      // clock can never cut a pulse below one dead time
      phase_d = ~phase_q;
      hold_d  = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      phase_q <= 1'b0;
      hold_q  <= '0;
    end else begin
      phase_q <= phase_d;
      hold_q  <= hold_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Soft start: gate duty ramps from zero to full

  logic [SW-1:0]        step_q, step_d;
  logic [RAMP_BITS-1:0] level_q, level_d;
  logic [RAMP_BITS-1:0] pwm_q, pwm_d;
  logic                 ramping;
  logic                 gate_a, gate_b;
  logic                 pwm_on;

  assign ramping = ~(&level_q);

  always_comb begin
    step_d  = step_q;
    level_d = level_q;
    pwm_d   = pwm_q + RAMP_BITS'(1);
    // Restart ramp on power-up and each enable rise
    if (!run || (enable_in && !en_q)) begin
      step_d  = '0;
      level_d = '0;
      pwm_d   = '0;
    end else if (ramping) begin
      if (step_q >= SW'(STEP_CYC - 1)) begin
        step_d  = '0;
        level_d = level_q + RAMP_BITS'(1);
      end else begin
        step_d = step_q + SW'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      step_q  <= '0;
      level_q <= '0;
      pwm_q   <= '0;
    end else begin
      step_q  <= step_d;
      level_q <= level_d;
      pwm_q   <= pwm_d;
    end
  end

  // Chopping only trims on-time, never dead time
  assign pwm_on          = ~ramping | (pwm_q < level_q);
  assign soft_start_busy = run & ramping;

  ////////////////////////////////////////////////////////////////////////////
  // Break-before-make and output stage

  ppgd_dead_time #(
    .DEAD_CYC (DEAD_CYC)
  ) u_dead_time (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .run      (run),
    .phase    (phase_q),
    .gate_a   (gate_a),
    .gate_b   (gate_b),
    .in_dead  ()
  );

  logic oa_q, oa_d;
  logic ob_q, ob_d;

  always_comb begin
    oa_d = run & gate_a & pwm_on;
    ob_d = run & gate_b & pwm_on;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      oa_q <= 1'b0;
      ob_q <= 1'b0;
    end else begin
      oa_q <= oa_d;
      ob_q <= ob_d;
    end
  end

  // Open drain: pull low when the switch conducts, released otherwise
  assign drain_out_a    = 1'b0;
  assign drain_out_b    = 1'b0;
  assign drain_out_a_oe = oa_q;
  assign drain_out_b_oe = ob_q;

endmodule : ppgd_sequencer
`default_nettype wire

/* ppgd_sequencer_sva.sv */
// Port checker for the gate drive sequencer: overlap, dead time, shutdown, clock source.
// Assumes the bench holds the supply flags steady around enable edges.
`timescale 1ns/1ns
`default_nettype none
module ppgd_sequencer_sva #(
  parameter bit HIGH_FREQ    = 1'b0,
  parameter int EXT_FAIL_CNT = 1250,
  parameter int SOFT_CNT     = 125000
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic enable_in,
  input wire logic ext_clk_in,
  input wire logic supply_start_ok,
  input wire logic supply_above_lockout,
  input wire logic drain_out_a,
  input wire logic drain_out_a_oe,
  input wire logic drain_out_b,
  input wire logic drain_out_b_oe,
  input wire logic ext_clock_active,
  input wire logic soft_start_busy,
  input wire logic enable_pull_down,
  input wire logic ext_clk_pull_down
);
  localparam int DEAD_MIN = ((HIGH_FREQ ? 90 : 115) + 7) / 8;
  localparam int FAIL_MAX = EXT_FAIL_CNT + 3;
  localparam int SOFT_MAX = SOFT_CNT + 8;
  logic [15:0] gap_q, gap_d, since_q, since_d;
  logic [31:0] busy_q, busy_d;
  logic        prev_q, last_b_q, last_b_d;
  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    gap_d    = (drain_out_a_oe || drain_out_b_oe) ? 16'h0000 : gap_q + 16'h0001;
    since_d  = (ext_clk_in && !prev_q) ? 16'h0000 : since_q + 16'h0001;
    busy_d   = soft_start_busy ? busy_q + 32'h00000001 : 32'h00000000;
    last_b_d = drain_out_b_oe || (last_b_q && !drain_out_a_oe);
  end
  // Last side starts as B so the first A pulse after reset is checked too
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gap_q    <= 16'h0000;
      since_q  <= 16'h0000;
      busy_q   <= 32'h00000000;
      prev_q   <= 1'b0;
      last_b_q <= 1'b1;
    end else begin
      gap_q    <= gap_d;
      since_q  <= since_d;
      busy_q   <= busy_d;
      prev_q   <= ext_clk_in;
      last_b_q <= last_b_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_no_overlap: assert property (!(drain_out_a_oe && drain_out_b_oe))
    else $error("both switches on");
  a_dead_gap: assert property (($rose(drain_out_a_oe) && last_b_q) ||
    ($rose(drain_out_b_oe) && !last_b_q) |-> gap_q >= DEAD_MIN) else $error("dead time short");
  a_reset_off: assert property (disable iff (1'b0) !rst_n |=>
    !drain_out_a_oe && !drain_out_b_oe && !ext_clock_active) else $error("active in reset");
  a_lockout_off: assert property (!supply_above_lockout [*4] |->
    !drain_out_a_oe && !drain_out_b_oe) else $error("drive below lockout");
  a_disable_off: assert property (!enable_in [*3] |->
    !drain_out_a_oe && !drain_out_b_oe) else $error("drive while disabled");
  a_pulls_on: assert property (enable_pull_down && ext_clk_pull_down &&
    !drain_out_a && !drain_out_b) else $error("pull-down or drain level wrong");
  a_ext_fallback: assert property (ext_clock_active |-> since_q <= FAIL_MAX)
    else $error("stale external clock kept");
  a_ext_lock: assert property ($rose(ext_clock_active) |-> since_q <= 4)
    else $error("lock without edge");
  a_soft_rise: assert property ($rose(enable_in) && supply_start_ok &&
    $past(supply_start_ok) && supply_above_lockout && $past(supply_above_lockout) &&
    $past(rst_n, 2) |=> soft_start_busy) else $error("no soft start");
  a_soft_bound: assert property (busy_q <= SOFT_MAX)
    else $error("soft start too long");
endmodule : ppgd_sequencer_sva
bind ppgd_sequencer ppgd_sequencer_sva #(
  .HIGH_FREQ(HIGH_FREQ), .EXT_FAIL_CNT(EXT_FAIL_CNT), .SOFT_CNT(SOFT_CNT)
) chk_u (
  .core_clk(core_clk), .rst_n(rst_n), .enable_in(enable_in), .ext_clk_in(ext_clk_in),
  .supply_start_ok(supply_start_ok), .supply_above_lockout(supply_above_lockout),
  .drain_out_a(drain_out_a), .drain_out_a_oe(drain_out_a_oe), .drain_out_b(drain_out_b),
  .drain_out_b_oe(drain_out_b_oe), .ext_clock_active(ext_clock_active),
  .soft_start_busy(soft_start_busy), .enable_pull_down(enable_pull_down),
  .ext_clk_pull_down(ext_clk_pull_down));
`default_nettype wire

/* test_push_pull_gate_drive_sequencer.sv */
// Self-checking bench for the gate drive sequencer: power rows, soft start, clock source.
// Assumes the checker is bound by its own file and the far side model is compiled.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_push_pull_gate_drive_sequencer;
  import ppgd_pkg::*;
  localparam int FAIL = 1250;
  localparam int SOFT = 512;
  localparam int EXTP = 400;
  localparam int RAMP = 255 * (SOFT / 256);
  localparam int ILO  = OSC_HALF_LF_CYC + 1;
  localparam int IHI  = OSC_HALF_LF_CYC + SPREAD_SPAN;
  typedef struct packed { logic en; logic sok; logic slo; logic sw; } ppgd_row_t;
  ppgd_row_t rows [6] = '{4'h6, 4'hF, 4'hB, 4'h8, 4'hA, 4'hF};
  logic      core_clk = 1'b0;
  logic      rst_n    = 1'b0;
  logic      en       = 1'b0;
  logic      sok      = 1'b1;
  logic      slo      = 1'b1;
  logic      ext_run  = 1'b0;
  wire logic ext_clk, pin_a, pin_b, ea, eb, da, db, act, busy, pen, pcl;
  int        mismatches = 0;
  int        check_count = 0;
  int        cyc = 0, last_t = 0, side = 2, skip = 2, first_side = 2, k;
  int        iv[$];
  always #4 core_clk = ~core_clk;
  ppgd_sequencer #(.HIGH_FREQ(1'b0), .EXT_FAIL_CNT(FAIL), .SOFT_CNT(SOFT)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .enable_in(en), .ext_clk_in(ext_clk),
    .supply_start_ok(sok), .supply_above_lockout(slo), .drain_out_a(da),
    .drain_out_a_oe(ea), .drain_out_b(db), .drain_out_b_oe(eb), .ext_clock_active(act),
    .soft_start_busy(busy), .enable_pull_down(pen), .ext_clk_pull_down(pcl));
  ppgd_far_side #(.HALF(EXTP / 2)) far_u (.core_clk(core_clk), .ext_run(ext_run),
    .oe_a(ea), .oe_b(eb), .val_a(da), .val_b(db), .ext_clk(ext_clk),
    .pin_a(pin_a), .pin_b(pin_b));
  ////////////////////////////////////////////////////////////////////////////////
  // First two side changes after a clear may start mid-pulse, so they are skipped
  always @(posedge core_clk) begin
    cyc++;
    if ((!pin_a || !pin_b) && (pin_a ? 1 : 0) != side) begin
      if (side == 2) first_side = pin_a ? 1 : 0;
      if (skip > 0) skip--;
      else if (!busy) iv.push_back(cyc - last_t);
      side   = pin_a ? 1 : 0;
      last_t = cyc;
    end
  end
  task automatic clear();
    side = 2;
    skip = 2;
    iv.delete();
  endtask : clear
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic wait_on(input logic use_busy, input logic v, input int n, output int c);
    for (c = 0; c < n; c++) begin
      if ((use_busy ? busy : act) === v) break;
      @(posedge core_clk);
      #2;
    end
    if (c == n) begin
      mismatches++;
      report_and_stop();
    end
  endtask : wait_on
  task automatic check_iv(input int lo, input int hi, input logic spread);
    int mn, mx;
    mn = hi + 1000;
    mx = 0;
    `CHK(iv.size() > 4, 1'b1)
    foreach (iv[j]) begin
      `CHK(iv[j] >= lo && iv[j] <= hi, 1'b1)
      mn = (iv[j] < mn) ? iv[j] : mn;
      mx = (iv[j] > mx) ? iv[j] : mx;
    end
    `CHK(mx > mn, spread)
  endtask : check_iv
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    #2 `CHK({ea, eb, act, pen, pcl}, 5'h03)
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      {en, sok, slo} <= rows[i][3:1];
      repeat (1200) @(posedge core_clk);
      #2 clear();
      repeat (800) @(posedge core_clk);
      #2 `CHK(side != 2, rows[i].sw)
    end
    @(posedge core_clk);
    en <= 1'b0;
    repeat (20) @(posedge core_clk);
    en <= 1'b1;
    #2 clear();
    @(posedge core_clk);
    #2 `CHK(busy, 1'b1)
    wait_on(1'b1, 1'b0, 1000, k);
    `CHK(k >= RAMP - 12 && k <= RAMP + 2, 1'b1)
    `CHK(first_side, 0)
    clear();
    repeat (4000) @(posedge core_clk);
    #2 check_iv(ILO, IHI, 1'b1);
    @(posedge core_clk);
    ext_run <= 1'b1;
    wait_on(1'b0, 1'b1, 6 * EXTP, k);
    clear();
    repeat (4000) @(posedge core_clk);
    #2 check_iv(EXTP, EXTP, 1'b0);
    @(posedge core_clk);
    ext_run <= 1'b0;
    wait_on(1'b0, 1'b0, FAIL + 20, k);
    `CHK(k >= FAIL - EXTP && k <= FAIL + 3, 1'b1)
    clear();
    repeat (4000) @(posedge core_clk);
    #2 check_iv(ILO, IHI, 1'b1);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    #2 `CHK({ea, eb, act}, 3'h0)
    @(posedge core_clk);
    rst_n <= 1'b1;
    clear();
    repeat (2) @(posedge core_clk);
    #2 `CHK({ea, eb, act}, 3'h0)
    repeat (800) @(posedge core_clk);
    #2 `CHK({side != 2, first_side == 0}, 2'h3)
    report_and_stop();
  end
endmodule : test_push_pull_gate_drive_sequencer
`default_nettype wire
